// *** verilog/vemc_controls.sv ***
`timescale 1ns/1ps
`include "vemc_defs.svh"
// Notes on behaviour
// [R1] colour bar replaces port data when set
// [R2] slave, accept clear: resync at odd field
// [R3] slave, accept set: follow external vsync
// [R4] triggers from pins or embedded codes
// [R5] dematrix active unless bypass bit set
// [R6] sync pin: hsync or composite form
// [R7] luma two's complement or straight binary
// [R8] chroma two's complement or straight binary
// [R9] programming data on line 16 when enabled
// [R10] monitor vsync pin: vsync or constant
// [R11] constant level follows general-purpose level
// [R12] sample on nominal or opposite edge
// [R13] slot correction swaps edge assignment
// [R14] bytes 5,11-14 sent line 16, lsb first
// [R15] subcarrier phase field, resets to zero
// [R16] host loads standard phase values
// [R17] blue gain zero gives no U
// [R18] red gain zero gives no V
// [R19] six-bit black level field
// [R20] host loads recommended black level
// [R21] gain halves joined into one value
module vemc_controls
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // register port
  input  wire logic [7:0]           regAddr,
  input  wire logic [7:0]           regWrData,
  input  wire logic                 regWrite,
  input  wire logic                 regRead,
  output logic      [7:0]           regRdData,
  // pins from the graphics controller
  input  wire logic [7:0]           pixel_data_port,
  input  wire logic                 frame_sync_pin,
  input  wire logic                 vertical_sync_in_pin,
  input  wire logic                 horizontal_sync_in_pin,
  // internal timing
  input  wire logic                 slaveMode,
  input  wire logic                 oddFieldStart,
  input  wire logic                 embeddedVTrig,
  input  wire logic                 embeddedHTrig,
  input  wire logic                 lineStart,
  input  wire logic [9:0]           lineNumber,
  input  wire logic                 bitTick,
  input  wire logic                 xtalCsync,
  input  wire logic                 pixelHsync,
  input  wire logic                 monitorVsync,
  input  wire logic [7:0]           colourBarData,
  // outputs
  output logic      [7:0]           encodeData,
  output logic                      resyncPulse,
  output logic                      hTrigger,
  output logic                      vTrigger,
  output logic                      monitor_hsync_pin,
  output logic                      monitor_vsync_pin,
  output logic                      vpsBit,
  output logic                      vpsActive,
  output logic                      sampleOnRise,
  output logic                      slotSwap,
  output vemc_pkg::vemc_ctrl_type   ctrl
);

  ////////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0] modeReg_r;
  logic [7:0] vpsCtlReg_r;
  logic [7:0] vpsByte_r [0:4];
  logic [7:0] phaseReg_r;
  logic [7:0] gainULoReg_r;
  logic [7:0] gainVLoReg_r;
  logic [7:0] blackReg_r;
  logic [7:0] gainVHiReg_r;
  logic [7:0] rdData_nxt;
  logic       vpsActive_r;

  // write strobes per subaddress
  wire wrMode   = regWrite && (regAddr == `VEMC_ADDR_MODE);
  wire wrVpsCtl = regWrite && (regAddr == `VEMC_ADDR_VPSCTL);
  wire wrPhase  = regWrite && (regAddr == `VEMC_ADDR_PHASE);
  wire wrGainU  = regWrite && (regAddr == `VEMC_ADDR_BLUE_DIFF_GAIN_LO);
  wire wrGainV  = regWrite && (regAddr == `VEMC_ADDR_RED_DIFF_GAIN_LO);
  wire wrBlack  = regWrite && (regAddr == `VEMC_ADDR_BLACK);
  wire wrGainVH = regWrite && (regAddr == `VEMC_ADDR_RED_DIFF_GAIN_HI);
  wire inVps    = (regAddr >= `VEMC_ADDR_VPS_BYTE_FIVE) &&
                  (regAddr <= `VEMC_ADDR_VPS_BYTE_FOURTEEN);
  wire [2:0] vpsIdx = 3'(regAddr - `VEMC_ADDR_VPS_BYTE_FIVE);

  // control registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      modeReg_r    <= `VEMC_RST_MODE;
      vpsCtlReg_r  <= `VEMC_RST_VPSCTL;
      phaseReg_r   <= `VEMC_RST_ZERO; // R15
      gainULoReg_r <= `VEMC_RST_ZERO;
      gainVLoReg_r <= `VEMC_RST_ZERO;
      blackReg_r   <= `VEMC_RST_ZERO;
      gainVHiReg_r <= `VEMC_RST_ZERO;
    end
    else
    begin
      if (wrMode)   modeReg_r    <= regWrData;
      if (wrVpsCtl) vpsCtlReg_r  <= regWrData;
      if (wrPhase)  phaseReg_r   <= regWrData;
      if (wrGainU)  gainULoReg_r <= regWrData;
      if (wrGainV)  gainVLoReg_r <= regWrData;
      if (wrBlack)  blackReg_r   <= regWrData;
      if (wrGainVH) gainVHiReg_r <= regWrData;
    end
  end

  // held programming data bytes; only five are kept
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 5; i++)
        vpsByte_r[i] <= `VEMC_RST_ZERO;
    end
    else if (regWrite && inVps)
    begin
      vpsByte_r[vpsIdx] <= regWrData; // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // field decode
  assign ctrl.colourBarSelect      = modeReg_r[`VEMC_BIT_CBAR];
  assign ctrl.slaveVerticalAccept  = modeReg_r[`VEMC_BIT_SVACC];
  assign ctrl.embeddedTimingSelect = modeReg_r[`VEMC_BIT_EMBED];
  assign ctrl.dematrixBypass       = modeReg_r[`VEMC_BIT_DEMBYP];
  assign ctrl.syncFormSelect       = modeReg_r[`VEMC_BIT_SYNCF];
  assign ctrl.lumaFormat           = modeReg_r[`VEMC_BIT_LUMAF];
  assign ctrl.chromaFormat         = modeReg_r[`VEMC_BIT_CHROMAF];
  assign ctrl.insertEnable         = vpsCtlReg_r[`VEMC_BIT_PROGRAMMING_DATA_INSERT_ENABLE];
  assign ctrl.gpLevel              = vpsCtlReg_r[`VEMC_BIT_GENERAL_PURPOSE_LEVEL];
  assign ctrl.gpEnable             = vpsCtlReg_r[`VEMC_BIT_GENERAL_PURPOSE_ENABLE];
  assign ctrl.samplePolarity       = vpsCtlReg_r[`VEMC_BIT_EDGE];
  assign ctrl.slotCorrection       = vpsCtlReg_r[`VEMC_BIT_SLOT];
  assign ctrl.subcarrierPhase      = phaseReg_r; // R15
  // gain high bits sit in the black-level and blanking registers
  assign ctrl.blueDiffGain = {blackReg_r[7:6], gainULoReg_r}; // R21 R17
  assign ctrl.redDiffGain  = {gainVHiReg_r[7:6], gainVLoReg_r}; // R21 R18
  assign ctrl.blackLevel   = blackReg_r[5:0]; // R19

  // readback mux; unmapped subaddresses read zero
  always_comb
  begin
    rdData_nxt = 8'h00;
    if (inVps)
      rdData_nxt = vpsByte_r[vpsIdx];
    case (regAddr)
      `VEMC_ADDR_MODE:     rdData_nxt = modeReg_r;
      `VEMC_ADDR_VPSCTL:   rdData_nxt = vpsCtlReg_r;
      `VEMC_ADDR_PHASE:    rdData_nxt = phaseReg_r;
      `VEMC_ADDR_BLUE_DIFF_GAIN_LO: rdData_nxt = gainULoReg_r;
      `VEMC_ADDR_RED_DIFF_GAIN_LO: rdData_nxt = gainVLoReg_r;
      `VEMC_ADDR_BLACK:    rdData_nxt = blackReg_r;
      `VEMC_ADDR_RED_DIFF_GAIN_HI: rdData_nxt = gainVHiReg_r;
      `VEMC_ADDR_STATUS:   rdData_nxt = {7'h00, vpsActive_r};
      default:             ;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      regRdData <= 8'h00;
    else
      regRdData <= regRead ? rdData_nxt : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers, first stage read only by second
  logic [7:0] pdMeta_r, pdSync_r;
  logic [2:0] pinMeta_r, pinSync_r;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pdMeta_r  <= 8'h00;
      pdSync_r  <= 8'h00;
      pinMeta_r <= 3'h0;
      pinSync_r <= 3'h0;
    end
    else
    begin
      pdMeta_r  <= pixel_data_port;
      pdSync_r  <= pdMeta_r;
      pinMeta_r <= {frame_sync_pin, vertical_sync_in_pin,
                    horizontal_sync_in_pin};
      pinSync_r <= pinMeta_r;
    end
  end

  // input format: straight binary converted by flipping the sign bit
  wire [7:0] lumaIn   = ctrl.lumaFormat ? pdSync_r : pdSync_r ^ 8'h80; // R7
  wire [7:0] chromaIn = ctrl.chromaFormat ? pdSync_r :
                        pdSync_r ^ 8'h80; // R8
  // alternate samples are luma and chroma
  logic       lumaPhase_r;
  wire  [7:0] portSample = lumaPhase_r ? lumaIn : chromaIn;

  // source select and input phase tracking
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      encodeData  <= 8'h00;
      lumaPhase_r <= 1'b0;
    end
    else
    begin
      lumaPhase_r <= ~lumaPhase_r;
      encodeData  <= ctrl.colourBarSelect ? colourBarData
                                          : portSample; // R1
    end
  end

  // sampling edge and slot; the capture stage lives outside
  assign sampleOnRise = ctrl.samplePolarity; // R12
  assign slotSwap     = ctrl.slotCorrection; // R13

  ////////////////////////////////////////////////////////////////////////
  // trigger source selection; frame sync stands in for both pins
  wire pinVTrig = pinSync_r[2] | pinSync_r[1];
  wire pinHTrig = pinSync_r[2] | pinSync_r[0];
  assign vTrigger = ctrl.embeddedTimingSelect ? embeddedVTrig
                                              : pinVTrig; // R4
  assign hTrigger = ctrl.embeddedTimingSelect ? embeddedHTrig
                                              : pinHTrig; // R4

  // vertical edge for slave resync
  logic vTrigPrev_r;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      vTrigPrev_r <= 1'b0;
    else
      vTrigPrev_r <= vTrigger;
  end
  wire vTrigRise = vTrigger & ~vTrigPrev_r;
  assign resyncPulse = slaveMode &&
    (ctrl.slaveVerticalAccept ? vTrigRise // R3
                              : (vTrigRise && oddFieldStart)); // R2

  // sync output form; dematrix bypass goes to the datapath via ctrl
  assign monitor_hsync_pin = ctrl.syncFormSelect ? xtalCsync
                                                 : pixelHsync; // R6
  assign monitor_vsync_pin = ctrl.gpEnable ? ctrl.gpLevel // R11
                                           : monitorVsync; // R10

  ////////////////////////////////////////////////////////////////////////
  // programming data serialiser: 40 bits, lsb first, on line 16
  vemc_pkg::vemc_vps_state_type state_r;
  logic [39:0] shift_r;
  logic [5:0]  bitCnt_r;
  wire startLine = lineStart && (lineNumber == `VEMC_VPS_LINE) &&
                   ctrl.insertEnable; // R9
  wire lastBit   = (bitCnt_r == 6'd39);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r  <= vemc_pkg::VPS_IDLE;
      shift_r  <= 40'h00_0000_0000;
      bitCnt_r <= 6'd0;
    end
    else
    begin
      case (state_r)
        vemc_pkg::VPS_IDLE:
          if (startLine)
          begin
            shift_r  <= {vpsByte_r[4], vpsByte_r[3], vpsByte_r[2],
                         vpsByte_r[1], vpsByte_r[0]}; // R14
            bitCnt_r <= 6'd0;
            state_r  <= vemc_pkg::VPS_SEND;
          end
        vemc_pkg::VPS_SEND:
          if (!ctrl.insertEnable)
            state_r <= vemc_pkg::VPS_IDLE; // R9
          else if (bitTick)
          begin
            shift_r  <= {1'b0, shift_r[39:1]}; // R14
            bitCnt_r <= 6'(bitCnt_r + 6'd1);
            if (lastBit)
              state_r <= vemc_pkg::VPS_DONE;
          end
        vemc_pkg::VPS_DONE:
          if (lineStart)
            state_r <= vemc_pkg::VPS_IDLE;
        default:
          state_r <= vemc_pkg::VPS_IDLE;
      endcase
    end
  end

  assign vpsActive_r = (state_r == vemc_pkg::VPS_SEND);
  assign vpsActive   = vpsActive_r;
  assign vpsBit      = vpsActive_r & shift_r[0];

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_colour_bar_src: assert property (@(posedge clk) disable iff (!reset_n)
    ctrl.colourBarSelect |=> encodeData == $past(colourBarData))
    else $error("colour bar not selected"); // R1
  a_odd_field_only: assert property (@(posedge clk) disable iff (!reset_n)
    resyncPulse && !ctrl.slaveVerticalAccept |-> oddFieldStart)
    else $error("resync outside odd field"); // R2
  a_vsync_follow: assert property (@(posedge clk) disable iff (!reset_n)
    slaveMode && ctrl.slaveVerticalAccept && vTrigger && !vTrigPrev_r
    |-> resyncPulse)
    else $error("external vsync ignored"); // R3
  a_trig_embedded: assert property (@(posedge clk) disable iff (!reset_n)
    ctrl.embeddedTimingSelect |-> vTrigger == embeddedVTrig)
    else $error("embedded trigger not used"); // R4
  a_sync_form: assert property (@(posedge clk) disable iff (!reset_n)
    !ctrl.syncFormSelect |-> monitor_hsync_pin == pixelHsync)
    else $error("sync pin form wrong"); // R6
  a_gp_level: assert property (@(posedge clk) disable iff (!reset_n)
    ctrl.gpEnable |-> monitor_vsync_pin == ctrl.gpLevel)
    else $error("constant level wrong"); // R11
  a_vsm_normal: assert property (@(posedge clk) disable iff (!reset_n)
    !ctrl.gpEnable |-> monitor_vsync_pin == monitorVsync)
    else $error("monitor vsync not passed"); // R10
  a_vps_gate: assert property (@(posedge clk) disable iff (!reset_n)
    !ctrl.insertEnable |=> !vpsActive)
    else $error("insertion while disabled"); // R9
  a_vps_lsb: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(vpsActive) |-> vpsBit == vpsByte_r[0][0])
    else $error("first bit not lsb"); // R14

endmodule

// *** verilog/vemc_defs.svh ***
`ifndef VEMC_DEFS_SVH
`define VEMC_DEFS_SVH
// subaddresses
`define VEMC_ADDR_MODE      8'h3A
`define VEMC_ADDR_VPSCTL    8'h54
`define VEMC_ADDR_VPS_BYTE_FIVE      8'h55
`define VEMC_ADDR_VPS_BYTE_ELEVEN     8'h56
`define VEMC_ADDR_VPS_BYTE_TWELVE     8'h57
`define VEMC_ADDR_VPS_BYTE_THIRTEEN     8'h58
`define VEMC_ADDR_VPS_BYTE_FOURTEEN     8'h59
`define VEMC_ADDR_PHASE     8'h5A
`define VEMC_ADDR_BLUE_DIFF_GAIN_LO  8'h5B
`define VEMC_ADDR_RED_DIFF_GAIN_LO  8'h5C
`define VEMC_ADDR_BLACK     8'h5D
`define VEMC_ADDR_RED_DIFF_GAIN_HI  8'h5E
`define VEMC_ADDR_STATUS    8'h5F
// mode register bit positions
`define VEMC_BIT_CBAR       7
`define VEMC_BIT_SVACC      6
`define VEMC_BIT_EMBED      5
`define VEMC_BIT_DEMBYP     4
`define VEMC_BIT_SYNCF      3
`define VEMC_BIT_LUMAF      1
`define VEMC_BIT_CHROMAF    0
// sampling control bit positions
`define VEMC_BIT_PROGRAMMING_DATA_INSERT_ENABLE      7
`define VEMC_BIT_GENERAL_PURPOSE_LEVEL      6
`define VEMC_BIT_GENERAL_PURPOSE_ENABLE       5
`define VEMC_BIT_EDGE       1
`define VEMC_BIT_SLOT       0
// reset values
`define VEMC_RST_MODE       8'h03
`define VEMC_RST_VPSCTL     8'h02
`define VEMC_RST_ZERO       8'h00
// line that carries programming data
`define VEMC_VPS_LINE       10'h010
`endif

// *** verilog/vemc_pkg.sv ***
package vemc_pkg;
  // decoded control fields
  typedef struct packed {
    logic       colourBarSelect;
    logic       slaveVerticalAccept;
    logic       embeddedTimingSelect;
    logic       dematrixBypass;
    logic       syncFormSelect;
    logic       lumaFormat;
    logic       chromaFormat;
    logic       insertEnable;
    logic       gpLevel;
    logic       gpEnable;
    logic       samplePolarity;
    logic       slotCorrection;
    logic [7:0] subcarrierPhase;
    logic [9:0] blueDiffGain;
    logic [9:0] redDiffGain;
    logic [5:0] blackLevel;
  } vemc_ctrl_type;
  // programming data serialiser states
  typedef enum logic [2:0] {
    VPS_IDLE = 3'b001,
    VPS_SEND = 3'b010,
    VPS_DONE = 3'b100
  } vemc_vps_state_type;
endpackage

// *** testbench/vemc_gfx_model.sv ***
`timescale 1ns/1ps
////////////////////////////////////////
// graphics controller: commanded pixel bytes, free-running syncs
module vemc_gfx_model
(
  // clock
  input  wire logic       clk,
  // byte the bench wants on the port
  input  wire logic [7:0] pixelCmd,
  // pins toward the encoder
  output logic      [7:0] pixel_data_port,
  output logic            frame_sync_pin,
  output logic            vertical_sync_in_pin,
  output logic            horizontal_sync_in_pin
);
  // defined levels from time zero, the encoder samples at once
  initial
  begin
    pixel_data_port = 8'h00;
    {frame_sync_pin, vertical_sync_in_pin, horizontal_sync_in_pin} = 3'h0;
  end
  // launch after the edge; syncs wander so no pin path goes quiet
  always @(posedge clk)
  begin
    pixel_data_port <= pixelCmd;
    {frame_sync_pin, vertical_sync_in_pin, horizontal_sync_in_pin}
      <= 3'($urandom);
  end
endmodule

// *** testbench/video_encoder_mode_controls_tb.sv ***
`timescale 1ns/1ps
module video_encoder_mode_controls_tb;
  logic                    clk, reset_n, regWrite, regRead, lineStart;
  logic                    slaveMode, oddFieldStart, embeddedVTrig;
  logic                    embeddedHTrig, bitTick, xtalCsync, pixelHsync;
  logic                    monitorVsync, frame_sync_pin, vpsBit, vpsActive;
  logic                    vertical_sync_in_pin, horizontal_sync_in_pin;
  logic                    resyncPulse, hTrigger, vTrigger, sampleOnRise;
  logic                    slotSwap, monitor_hsync_pin, monitor_vsync_pin;
  logic                    cbLast, vPrev;
  logic [9:0]              lineNumber;
  logic [7:0]              regAddr, regWrData, regRdData, pixelCmd;
  logic [7:0]              colourBarData, cbPrev, encodeData;
  logic [7:0]              pixel_data_port;
  logic [7:0]              mdl [0:255];
  logic [7:0]              tbl [0:13] = '{8'h3A, 8'h54, 8'h55, 8'h56,
    8'h57, 8'h58, 8'h59, 8'h5A, 8'h5B, 8'h5C, 8'h5D, 8'h5E, 8'h5F, 8'h40};
  vemc_pkg::vemc_ctrl_type ctrl;
  int                      mismatches, num_checks, cycles;

  vemc_controls u_vemc_controls (.clk, .reset_n, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .pixel_data_port, .frame_sync_pin,
    .vertical_sync_in_pin, .horizontal_sync_in_pin, .slaveMode,
    .oddFieldStart, .embeddedVTrig, .embeddedHTrig, .lineStart, .lineNumber,
    .bitTick, .xtalCsync, .pixelHsync, .monitorVsync, .colourBarData,
    .encodeData, .resyncPulse, .hTrigger, .vTrigger, .monitor_hsync_pin,
    .monitor_vsync_pin, .vpsBit, .vpsActive, .sampleOnRise, .slotSwap, .ctrl);
  vemc_gfx_model u_vemc_gfx_model (.clk, .pixelCmd, .pixel_data_port,
    .frame_sync_pin, .vertical_sync_in_pin, .horizontal_sync_in_pin);

  ////////////////////////////////////////
  // wide enough for the whole control struct
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // model follows a write only where a register really lives
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    if (a == 8'h3A || (a >= 8'h54 && a <= 8'h5E))
      mdl[a] = d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    check(regRdData, exp);
  endtask
  task automatic pulse_line(input logic [9:0] n);
    @(posedge clk);
    lineStart <= 1'b1;
    lineNumber <= n;
    @(posedge clk);
    lineStart <= 1'b0;
    @(negedge clk);
  endtask
  task automatic tick;
    @(posedge clk);
    bitTick <= 1'b1;
    @(posedge clk);
    bitTick <= 1'b0;
    @(negedge clk);
  endtask

  ////////////////////////////////////////
  // clock, and a hang guard well above the few hundred cycles needed
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      final_report;
    end
  end
  // timing inputs wander every cycle so each pin mux sees both arms
  always @(posedge clk)
  begin
    {slaveMode, oddFieldStart, embeddedVTrig, embeddedHTrig, xtalCsync,
      pixelHsync, monitorVsync} <= 7'($urandom);
    colourBarData <= 8'($urandom);
    cbPrev <= colourBarData;
    // previous vertical trigger, cleared like the design's while in reset
    vPrev <= reset_n ? vTrigger : 1'b0;
  end
  // comb outputs against the register model, off the launching edge
  always @(negedge clk)
    if (reset_n)
    begin
      check(monitor_vsync_pin,
        mdl[8'h54][5] ? mdl[8'h54][6] : monitorVsync);
      check(monitor_hsync_pin, mdl[8'h3A][3] ? xtalCsync : pixelHsync);
      check({sampleOnRise, slotSwap}, mdl[8'h54][1:0]);
      if (mdl[8'h3A][5])
        check({hTrigger, vTrigger}, {embeddedHTrig, embeddedVTrig});
      // resync needs a rising vertical trigger; odd field unless accepted
      check(resyncPulse, slaveMode & vTrigger & ~vPrev &
        (mdl[8'h3A][6] | oddFieldStart));
      if (mdl[8'h3A][7] && cbLast)
        check(encodeData, cbPrev);
      check(ctrl, {mdl[8'h3A][7:3], mdl[8'h3A][1:0], mdl[8'h54][7:5],
        mdl[8'h54][1:0], mdl[8'h5A], mdl[8'h5D][7:6], mdl[8'h5B],
        mdl[8'h5E][7:6], mdl[8'h5C], mdl[8'h5D][5:0]});
      cbLast = mdl[8'h3A][7];
    end

  ////////////////////////////////////////
  initial
  begin
    logic [7:0] v;
    {regWrite, regRead, lineStart, bitTick, cbLast, vPrev} = 6'h00;
    {regAddr, regWrData, pixelCmd, colourBarData, cbPrev} = 40'h0;
    lineNumber = 10'h000;
    for (int i = 0; i < 256; i++)
      mdl[i] = 8'h00;
    mdl[8'h3A] = 8'h03;
    mdl[8'h54] = 8'h02;
    reset_n = 1'b0;
    v = 8'($urandom(32'h61eebda6));
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    foreach (tbl[i])
      rd(tbl[i], mdl[tbl[i]]);
    // random traffic, unmapped and read-only places included
    repeat (60)
    begin
      v = tbl[$urandom % 14];
      wr(v, 8'($urandom));
      rd(v, mdl[v]);
    end
    foreach (tbl[i])
      if (i < 4)
      begin
        v = i[1] ? (i[0] ? 8'h46 : 8'h25) : (i[0] ? 8'h16 : 8'h6B);
        wr(8'h5A, v);
        rd(8'h5A, v);
      end
    wr(8'h5D, 8'h3A);
    rd(8'h5D, 8'h3A);
    wr(8'h5D, 8'h33);
    // two's complement passes, straight binary flips the sign
    for (int f = 0; f < 2; f++)
    begin
      wr(8'h3A, f ? 8'h03 : 8'h00);
      v = 8'($urandom);
      pixelCmd <= v;
      repeat (6) @(posedge clk);
      @(negedge clk);
      check(encodeData, f ? v : v ^ 8'h80);
    end
    wr(8'h3A, 8'h80);
    repeat (8) @(posedge clk);
    // serial burst only on line 16, five bytes lsb first
    wr(8'h54, 8'h82);
    for (int i = 0; i < 5; i++)
      wr(8'(8'h55 + i), 8'($urandom));
    pulse_line(10'h00F);
    check(vpsActive, 1'b0);
    pulse_line(10'h010);
    rd(8'h5F, 8'h01);
    for (int i = 0; i < 40; i++)
    begin
      check({vpsActive, vpsBit}, {1'b1, mdl[8'h55 + i / 8][i % 8]});
      tick;
    end
    check(vpsActive, 1'b0);
    pulse_line(10'h010);
    pulse_line(10'h010);
    check(vpsActive, 1'b1);
    tick;
    wr(8'h54, 8'h02);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(vpsActive, 1'b0);
    pulse_line(10'h010);
    check(vpsActive, 1'b0);
    final_report;
  end
endmodule
